// ---- dual_timer_params.svh ----
// Register offsets, field positions and reset values of the dual timer
`ifndef DUAL_TIMER_PARAMS_SVH
`define DUAL_TIMER_PARAMS_SVH
`define ADDR_CTRL0      3'h0
`define ADDR_CTRL1      3'h1
`define ADDR_COUNT0     3'h2
`define ADDR_COUNT1     3'h3
`define ADDR_IRQ_STATUS 3'h4
`define ADDR_IRQ_CLEAR  3'h5
`define ADDR_IRQ_ENABLE 3'h6
`define BIT_CLK_SEL     5
`define BIT_RUN         4
`define BIT_EDGE        3
`define CTRL_RESET      8'h08
`define CTRL1_MASK      8'hF8
`define COUNT_FULL      8'hFF
`define PRESCALE_ONES   7'h7F
`define DIV4_LAST       2'h3
`endif

// ---- dual_timer_pkg.sv ----
// Types of the dual timer/event counter
package dual_timer_pkg;
	typedef enum logic [1:0] {
		MODE_NONE    = 2'h0,
		MODE_EVENT   = 2'h1,
		MODE_TIMER   = 2'h2,
		MODE_CAPTURE = 2'h3
	} mode_t;

	typedef struct packed {
		logic [1:0][7:0] ctrl;
		logic [1:0][7:0] preload;
		logic [1:0][7:0] count;
		logic [1:0]      pinMeta;
		logic [1:0]      pinSync;
		logic [1:0]      pinPrev;
		logic [1:0]      capActive;
		logic [1:0]      status;
		logic [1:0]      irqEn;
		logic [6:0]      presc;
		logic [1:0]      div4;
		logic            lxtPrev;
		logic [7:0]      rdData;
	} timer_state_t;
endpackage

// ---- dual_timer_event_counter.sv ----
// Two 8-bit timer/event counters with register port and interrupt
`timescale 1ns/1ns
`include "dual_timer_params.svh"
module dual_timer_event_counter
	import dual_timer_pkg::*;
(
	// Clock and reset
	input  wire logic       clk,
	input  wire logic       rst_b,
	// Register port
	input  wire logic [2:0] addr,
	input  wire logic [7:0] wrData,
	input  wire logic       wrEn,
	input  wire logic       rdEn,
	output logic      [7:0] rdData,
	// Clock sources and device state
	input  wire logic       lowFreqCrystal,
	input  wire logic       pwmEnable,
	input  wire logic       sleepMode,
	// External count pins
	input  wire logic [1:0] extCountPin,
	// Interrupt and wake-up
	output logic            irq,
	output logic            wakeUp
);

	localparam timer_state_t ST_RESET = '{
		ctrl:    {`CTRL_RESET, `CTRL_RESET},
		default: '0
	};

	timer_state_t st_r;
	timer_state_t st_nxt;

	logic       sharedTick;
	logic       pscTick;
	logic       div4Tick;
	logic       lxtFall;
	logic [6:0] pscMask;
	logic [1:0] tick;
	logic [1:0] rise;
	logic [1:0] fall;
	logic [1:0] inc;
	logic [1:0] ovf;
	logic       run;
	logic       edg;
	logic       startEdge;
	logic       stopEdge;
	mode_t      mode;

	always_comb begin
		st_nxt    = st_r;
		sharedTick = 1'b0;
		inc       = 2'h0;
		ovf       = 2'h0;
		run       = 1'b0;
		edg       = 1'b0;
		startEdge = 1'b0;
		stopEdge  = 1'b0;
		mode      = MODE_NONE;

		// Crystal falling edge
		lxtFall = st_r.lxtPrev & ~lowFreqCrystal;
		st_nxt.lxtPrev = lowFreqCrystal;

		if (pwmEnable) begin
			sharedTick = ~sleepMode;
		end else if (st_r.ctrl[0][`BIT_CLK_SEL]) begin
			sharedTick = lxtFall;
		end else begin
			sharedTick = ~sleepMode;
		end

		// prescaler divide by power of two
		pscMask = ~(`PRESCALE_ONES << st_r.ctrl[0][2:0]);
		pscTick = sharedTick && ((st_r.presc & pscMask) == pscMask);
		if (sharedTick) begin
			st_nxt.presc = st_r.presc + 7'h01;
		end

		div4Tick = ~sleepMode && (st_r.div4 == `DIV4_LAST);
		if (~sleepMode) begin
			st_nxt.div4 = st_r.div4 + 2'h1;
		end
		tick[0] = pscTick;
		tick[1] = st_r.ctrl[1][`BIT_CLK_SEL] ? lxtFall : div4Tick;

		st_nxt.pinMeta = extCountPin;
		st_nxt.pinSync = st_r.pinMeta;
		st_nxt.pinPrev = st_r.pinSync;
		rise = st_r.pinSync & ~st_r.pinPrev;
		fall = ~st_r.pinSync & st_r.pinPrev;

		for (int i = 0; i < 2; i++) begin
			mode = mode_t'(st_r.ctrl[i][7:6]);
			run  = st_r.ctrl[i][`BIT_RUN];
			edg  = st_r.ctrl[i][`BIT_EDGE];
			startEdge = edg ? rise[i] : fall[i];
			stopEdge  = edg ? fall[i] : rise[i];
			unique case (mode)
				MODE_EVENT: begin
					inc[i] = run && (edg ? fall[i] : rise[i]);
				end
				MODE_TIMER: begin
					inc[i] = run && tick[i];
				end
				MODE_CAPTURE: begin
					if (!run) begin
						st_nxt.capActive[i] = 1'b0;
					end else if (!st_r.capActive[i]) begin
						st_nxt.capActive[i] = startEdge;
					end else if (stopEdge) begin
						st_nxt.capActive[i] = 1'b0;
						st_nxt.ctrl[i][`BIT_RUN] = 1'b0;
					end
					inc[i] = run && st_r.capActive[i] && !stopEdge && tick[i];
				end
				MODE_NONE: begin
					inc[i] = 1'b0;
				end
			endcase
			if (inc[i]) begin
				if (st_r.count[i] == `COUNT_FULL) begin
					st_nxt.count[i] = st_r.preload[i];
					ovf[i] = 1'b1;
				end else begin
					st_nxt.count[i] = st_r.count[i] + 8'h01;
				end
			end
		end

		// Register writes
		if (wrEn) begin
			case (addr)
				`ADDR_CTRL0: begin
					st_nxt.ctrl[0] = wrData;
					st_nxt.capActive[0] = 1'b0;
				end
				`ADDR_CTRL1: begin
					st_nxt.ctrl[1] = wrData & `CTRL1_MASK;
					st_nxt.capActive[1] = 1'b0;
				end
				`ADDR_COUNT0: begin
					// preload with direct load when stopped
					st_nxt.preload[0] = wrData;
					if (!st_r.ctrl[0][`BIT_RUN]) begin
						st_nxt.count[0] = wrData;
					end
				end
				`ADDR_COUNT1: begin
					// preload with direct load when stopped
					st_nxt.preload[1] = wrData;
					if (!st_r.ctrl[1][`BIT_RUN]) begin
						st_nxt.count[1] = wrData;
					end
				end
				`ADDR_IRQ_CLEAR: begin
					st_nxt.status = st_r.status & ~wrData[1:0];
				end
				`ADDR_IRQ_ENABLE: begin
					st_nxt.irqEn = wrData[1:0];
				end
				default: begin
					st_nxt.irqEn = st_r.irqEn;
				end
			endcase
		end

		// Register reads
		st_nxt.rdData = 8'h00;
		if (rdEn) begin
			case (addr)
				`ADDR_CTRL0:      st_nxt.rdData = st_r.ctrl[0];
				`ADDR_CTRL1:      st_nxt.rdData = st_r.ctrl[1] & `CTRL1_MASK;
				`ADDR_COUNT0:     st_nxt.rdData = st_r.count[0];
				`ADDR_COUNT1:     st_nxt.rdData = st_r.count[1];
				`ADDR_IRQ_STATUS: st_nxt.rdData = {6'h00, st_r.status};
				`ADDR_IRQ_ENABLE: st_nxt.rdData = {6'h00, st_r.irqEn};
				default:          st_nxt.rdData = 8'h00;
			endcase
		end

		st_nxt.status = st_nxt.status | ovf;
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			st_r <= ST_RESET;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign rdData = st_r.rdData;
	assign irq    = |(st_r.status & st_r.irqEn);
	assign wakeUp = sleepMode & irq;

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_b);

	property p_ctrl1_low;
		rdEn && (addr == `ADDR_CTRL1) |=> rdData[2:0] == 3'h0;
	endproperty
	a_ctrl1_low: assert property (p_ctrl1_low)
		else $error("Counter 1 control low bits not zero");

	property p_reload;
		(st_r.count[0] == `COUNT_FULL) && inc[0]
			&& !(wrEn && (addr == `ADDR_COUNT0))
		|=> (st_r.count[0] == $past(st_r.preload[0])) && st_r.status[0];
	endproperty
	a_reload: assert property (p_reload)
		else $error("Overflow did not reload or flag");

	property p_halt;
		!st_r.ctrl[0][`BIT_RUN] && !(wrEn && (addr == `ADDR_COUNT0))
		|=> $stable(st_r.count[0]);
	endproperty
	a_halt: assert property (p_halt)
		else $error("Stopped counter changed");

	property p_event_rise;
		(st_r.ctrl[0][7:6] == MODE_EVENT) && st_r.ctrl[0][`BIT_RUN]
			&& !st_r.ctrl[0][`BIT_EDGE] && rise[0]
			&& (st_r.count[0] != `COUNT_FULL)
			&& !(wrEn && (addr == `ADDR_COUNT0))
		|=> st_r.count[0] == $past(st_r.count[0]) + 8'h01;
	endproperty
	a_event_rise: assert property (p_event_rise)
		else $error("Rising edge not counted");

	property p_preload_stopped;
		wrEn && (addr == `ADDR_COUNT1) && !st_r.ctrl[1][`BIT_RUN]
		|=> st_r.count[1] == $past(wrData);
	endproperty
	a_preload_stopped: assert property (p_preload_stopped)
		else $error("Preload not copied to stopped counter");

	property p_cap_stop;
		(st_r.ctrl[0][7:6] == MODE_CAPTURE) && st_r.ctrl[0][`BIT_RUN]
			&& st_r.capActive[0] && !st_r.ctrl[0][`BIT_EDGE] && rise[0]
			&& !(wrEn && (addr == `ADDR_CTRL0))
		|=> !st_r.ctrl[0][`BIT_RUN] ##1 !st_r.ctrl[0][`BIT_RUN];
	endproperty
	a_cap_stop: assert property (p_cap_stop)
		else $error("Capture end did not clear run bit");

	property p_irq_set;
		ovf[0] && st_r.irqEn[0] && !(wrEn && (addr == `ADDR_IRQ_ENABLE))
		|=> irq;
	endproperty
	a_irq_set: assert property (p_irq_set)
		else $error("Enabled overflow gave no interrupt");

	property p_pwm_clock;
		pwmEnable && !sleepMode |-> sharedTick;
	endproperty
	a_pwm_clock: assert property (p_pwm_clock)
		else $error("PWM did not force system clock");

	property p_timer1;
		(st_r.ctrl[1][7:6] == MODE_TIMER) && st_r.ctrl[1][`BIT_RUN]
			&& tick[1] && (st_r.count[1] != `COUNT_FULL)
			&& !(wrEn && (addr == `ADDR_COUNT1))
		|=> st_r.count[1] == $past(st_r.count[1]) + 8'h01;
	endproperty
	a_timer1: assert property (p_timer1)
		else $error("Timer tick not counted");

	property p_event_fall;
		(st_r.ctrl[0][7:6] == MODE_EVENT) && st_r.ctrl[0][`BIT_RUN]
			&& st_r.ctrl[0][`BIT_EDGE] && fall[0]
			&& (st_r.count[0] != `COUNT_FULL)
			&& !(wrEn && (addr == `ADDR_COUNT0))
		|=> st_r.count[0] == $past(st_r.count[0]) + 8'h01;
	endproperty
	a_event_fall: assert property (p_event_fall)
		else $error("Falling edge not counted");

	property p_cap_start;
		(st_r.ctrl[0][7:6] == MODE_CAPTURE) && st_r.ctrl[0][`BIT_RUN]
			&& !st_r.capActive[0] && st_r.ctrl[0][`BIT_EDGE] && rise[0]
			&& !(wrEn && (addr == `ADDR_CTRL0))
		|=> st_r.capActive[0];
	endproperty
	a_cap_start: assert property (p_cap_start)
		else $error("Capture did not start on rising edge");

	property p_cap_stop_fall;
		(st_r.ctrl[0][7:6] == MODE_CAPTURE) && st_r.ctrl[0][`BIT_RUN]
			&& st_r.capActive[0] && st_r.ctrl[0][`BIT_EDGE] && fall[0]
			&& !(wrEn && (addr == `ADDR_CTRL0))
		|=> !st_r.ctrl[0][`BIT_RUN] && !st_r.capActive[0];
	endproperty
	a_cap_stop_fall: assert property (p_cap_stop_fall)
		else $error("Capture end on falling edge kept running");

	property p_event_sleep;
		(st_r.ctrl[1][7:6] == MODE_EVENT) && st_r.ctrl[1][`BIT_RUN]
			&& !st_r.ctrl[1][`BIT_EDGE] && rise[1] && sleepMode
			&& (st_r.count[1] != `COUNT_FULL)
			&& !(wrEn && (addr == `ADDR_COUNT1))
		|=> st_r.count[1] == $past(st_r.count[1]) + 8'h01;
	endproperty
	a_event_sleep: assert property (p_event_sleep)
		else $error("Event not counted in sleep");

	property p_ovf1_flag;
		ovf[1] |=> st_r.status[1];
	endproperty
	a_ovf1_flag: assert property (p_ovf1_flag)
		else $error("Counter 1 overflow not flagged");

	property p_wake;
		sleepMode && irq |-> wakeUp;
	endproperty
	a_wake: assert property (p_wake)
		else $error("Interrupt in sleep gave no wake-up");

	property p_mode_none;
		(st_r.ctrl[0][7:6] == MODE_NONE)
			&& !(wrEn && (addr == `ADDR_COUNT0))
		|=> $stable(st_r.count[0]);
	endproperty
	a_mode_none: assert property (p_mode_none)
		else $error("Counter moved with no mode");

	property p_sync_delay;
		rise[0] |-> $past(extCountPin[0], 2) && !$past(extCountPin[0], 3);
	endproperty
	a_sync_delay: assert property (p_sync_delay)
		else $error("Pin edge seen at wrong delay");

	property p_pwm_count;
		pwmEnable && !sleepMode
			&& (st_r.ctrl[0][7:6] == MODE_TIMER) && st_r.ctrl[0][`BIT_RUN]
			&& (st_r.ctrl[0][2:0] == 3'h0)
			&& (st_r.count[0] != `COUNT_FULL)
			&& !(wrEn && (addr == `ADDR_COUNT0))
		|=> st_r.count[0] == $past(st_r.count[0]) + 8'h01;
	endproperty
	a_pwm_count: assert property (p_pwm_count)
		else $error("PWM clock did not count every cycle");

	property p_ctrl1_write;
		wrEn && (addr == `ADDR_CTRL1) |=> st_r.ctrl[1][2:0] == 3'h0;
	endproperty
	a_ctrl1_write: assert property (p_ctrl1_write)
		else $error("Counter 1 control kept low bits");

endmodule // dual_timer_event_counter

// ---- pulse_src.sv ----
// External pulse source driving both count pins
`timescale 1ns/1ns
module pulse_src (
	// Clock
	input  wire logic       clk,
	// Count pins
	output logic      [1:0] pin
);
	initial pin = 2'h0;
	task automatic toggle(input int ch, input int w, input int n);
		repeat (n) begin
			@(posedge clk);
			pin[ch] <= ~pin[ch];
			repeat (w) @(posedge clk);
		end
	endtask
endmodule // pulse_src

// ---- dual_timer_event_counter_tb.sv ----
// Self-checking bench of the dual timer/event counter
`timescale 1ns/1ns
module dual_timer_event_counter_tb;
	logic        clk, rst_b, wrEn, rdEn, pwm, sleep, irq, wakeUp, rdPend;
	logic [2:0]  addr, xcnt;
	logic [7:0]  wrData, rdData, p, expV;
	logic [1:0]  pin;
	logic [31:0] lfsr;
	int          mismatches, checked, tolV, c, n, eg, ups;
	int          tolQ[$];
	logic [7:0]  expQ[$];

	dual_timer_event_counter uut (.clk(clk), .rst_b(rst_b), .addr(addr),
		.wrData(wrData), .wrEn(wrEn), .rdEn(rdEn), .rdData(rdData),
		.lowFreqCrystal(xcnt[2]), .pwmEnable(pwm), .sleepMode(sleep),
		.extCountPin(pin), .irq(irq), .wakeUp(wakeUp));
	pulse_src src (.clk(clk), .pin(pin));

	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	always @(posedge clk) xcnt <= rst_b ? 3'(xcnt + 3'h1) : 3'h0;

	function automatic logic [31:0] nextRand(input logic [31:0] v);
		return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction
	task automatic check(input logic [7:0] s, input logic [7:0] e);
		checked++;
		if (s !== e) begin
			mismatches++;
			$display("unexpected at %0t: seen %h expected %h", $time, s, e);
		end
	endtask
	task automatic give_verdict;
		$display("checked %0d mismatches %0d", checked, mismatches);
		if (mismatches == 0 && checked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wrData <= d;
		wrEn <= 1'b1;
		@(posedge clk);
		wrEn <= 1'b0;
	endtask
	task automatic rd(input logic [2:0] a, input logic [7:0] e, input int t);
		@(posedge clk);
		addr <= a;
		rdEn <= 1'b1;
		expQ.push_back(e);
		tolQ.push_back(t);
		@(posedge clk);
		rdEn <= 1'b0;
	endtask
	// Read data one cycle after the strobe
	always @(posedge clk) begin
		if (rdPend && expQ.size() > 0) begin
			expV = expQ.pop_front();
			tolV = tolQ.pop_front();
			check((8'(rdData - expV) <= tolV || 8'(expV - rdData) <= tolV)
				? expV : rdData, expV);
		end
		rdPend <= rdEn;
	end
	task automatic waitIrq;
		int i;
		for (i = 0; i < 60 && irq !== 1'b1; i++)
			@(negedge clk);
		if (irq !== 1'b1) begin
			mismatches++;
			give_verdict;
		end
	endtask
	task automatic tmr(input int k, input logic [7:0] ctl,
		input logic [7:0] pv, input int cyc, input logic [7:0] e);
		wr(3'(k + 2), pv);
		rd(3'(k + 2), pv, 0);
		wr(3'(k), ctl);
		repeat (cyc - 2) @(posedge clk);
		wr(3'(k), ctl & 8'hEF);
		repeat (40) @(posedge clk);
		rd(3'(k + 2), e, 1);
	endtask

	initial begin
		{rst_b, wrEn, rdEn, pwm, sleep} = 5'h00;
		addr = 3'h0;
		wrData = 8'h00;
		lfsr = 32'h00018067;
		repeat (12) @(posedge clk);
		rst_b <= 1'b1;
		rd(3'h0, 8'h08, 0);
		rd(3'h1, 8'h08, 0);
		rd(3'h4, 8'h00, 0);
		wr(3'h7, 8'hFF);
		rd(3'h7, 8'h00, 0);
		wr(3'h1, 8'h0F);
		rd(3'h1, 8'h08, 0);
		$display("register test done");
		for (n = 0; n < 8; n++) begin
			lfsr = nextRand(lfsr);
			p = {1'b0, lfsr[6:0]};
			tmr(0, 8'(8'h90 | n), p, 4 << n, 8'(p + 8'h04));
		end
		tmr(1, 8'h90, p, 16, 8'(p + 8'h04));
		for (c = 0; c < 2; c++)
			tmr(c, 8'hB0, 8'h00, 64, 8'h08);
		pwm <= 1'b1;
		tmr(0, 8'hB0, 8'h00, 16, 8'h10);
		pwm <= 1'b0;
		$display("timer test done");
		sleep <= 1'b1;
		for (c = 0; c < 2; c++)
			for (eg = 0; eg < 2; eg++) begin
				lfsr = nextRand(lfsr);
				p = {1'b0, lfsr[6:0]};
				ups = pin[c] ? 4 : 5;
				wr(3'(c + 2), p);
				wr(3'(c), 8'(8'h57 | (eg << 3)));
				src.toggle(c, 1, 9);
				repeat (6) @(posedge clk);
				wr(3'(c), 8'h40);
				rd(3'(c + 2), 8'(p + (eg ? 9 - ups : ups)), 0);
			end
		sleep <= 1'b0;
		$display("event test done");
		for (c = 0; c < 2; c++) begin
			eg = pin[c] ? 0 : 1;
			wr(3'(c + 2), 8'h00);
			wr(3'(c), 8'(8'hD0 | (eg << 3)));
			src.toggle(c, 40, 4);
			repeat (6) @(posedge clk);
			rd(3'(c + 2), c ? 8'h0A : 8'h29, 2);
			rd(3'(c), 8'(8'hC0 | (eg << 3)), 0);
		end
		$display("capture test done");
		wr(3'h6, 8'h03);
		wr(3'h2, 8'hFD);
		wr(3'h0, 8'h90);
		waitIrq;
		check({7'h00, irq}, 8'h01);
		rd(3'h4, 8'h01, 0);
		wr(3'h0, 8'h80);
		wr(3'h5, 8'h01);
		@(negedge clk);
		check({7'h00, irq}, 8'h00);
		wr(3'h6, 8'h02);
		wr(3'h0, 8'h90);
		repeat (20) @(negedge clk);
		check({7'h00, irq}, 8'h00);
		rd(3'h4, 8'h01, 0);
		wr(3'h0, 8'h80);
		sleep <= 1'b1;
		wr(3'h3, 8'hFE);
		wr(3'h1, 8'h50);
		src.toggle(1, 1, 4);
		waitIrq;
		check({7'h00, wakeUp}, 8'h01);
		rd(3'h4, 8'h03, 0);
		$display("interrupt test done");
		repeat (3) @(posedge clk);
		give_verdict;
	end
endmodule // dual_timer_event_counter_tb
